/* rtl/scm_mode_ctrl.sv */
// scm_mode_ctrl: system clock source select and halt mode control
// assumes apb master on ref_clk; oscillator ticks and halt come from
// the core's own logic; slow oscillator alive level arrives async
`timescale 1ns/1ps
// What this block does
// - high select uses undivided fast oscillator
// - source field picks slow or fast divisions
// - fast oscillator stops on move to slow
// - halt with idle off enters sleep
// - sleep without watchdog stops slow oscillator
// - sleep with watchdog keeps slow oscillator
// - idle clock-off stops cpu and system clock
// - idle clock-on keeps peripheral system clock
// - slow ready low in deep sleep
// - fast ready set once fast oscillator stable
// - fast run divides by one to sixty-four
// - keep-clock-in-idle bit seven resets zero
// - halt sets power-down, clears watchdog timeout
// - deep sleep stops and clears watchdog
module scm_mode_ctrl
	import scm_pkg::*;
(
	input  wire logic        ref_clk,         // 100 MHz clock
	input  wire logic        rst,             // sync reset, high
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb access phase
	input  wire logic        pwrite,          // apb direction
	input  wire logic [11:0] paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // apb error
	input  wire logic        fast_osc_tick,   // fast osc period pulse
	input  wire logic        slow_osc_tick,   // slow osc period pulse
	input  wire logic        slow_osc_alive,  // async slow osc level
	input  wire logic        halt_req,        // halt instruction pulse
	input  wire logic        wake_req,        // wake-up event pulse
	input  wire logic        watchdog_enable, // watchdog on level
	output logic             sys_clk_en,      // system clock enable
	output logic             cpu_clk_en,      // cpu clock enable
	output logic             fast_osc_on,     // fast oscillator run
	output logic             slow_osc_on,     // slow oscillator run
	output logic             time_base_clock, // time base tick
	output logic             watchdog_clk_en, // watchdog tick
	output logic             watchdog_clear,  // watchdog clear pulse
	output logic             power_down_flag, // set on halt
	output logic             watchdog_timeout_flag, // cleared on halt
	output scm_mode_t        mode             // current operating mode
);
	// how the block hangs together:
	// the oscillators are not clocks here, they are one-cycle enables on
	// ref_clk, so every downstream clock is an enable and never a gated
	// clock; this keeps one clock domain at the cost of enable fan-out
	// tap numbering, shared by cur_src and pend_src:
	//   0      slow oscillator
	//   1..6   fast divided by 64, 32, 16, 8, 4, 2
	//   7      fast undivided
	// the divider output index is seven minus the tap, so tap 7 reads
	// bit zero of fast_ticks and tap 1 reads bit six
	// run modes follow the tap in use: slow run when tap is zero
	// halt is honoured only in a run mode; a halt while already stopped
	// is dropped, so a second halt pulse cannot re-enter a stop state
	// wake is honoured only in a stop mode and returns to the run mode
	// that matches the tap in use when the wake arrives
	// a source change is not applied at once: the old source must tick
	// four times, then the switch waits for one tick of the target, so
	// both clocks have been seen at an edge before the tap moves
	// limitation: a new request during a pending switch restarts the
	// count, so software that rewrites the field keeps the old clock
	// a fast target also waits for the fast ready flag, which restarts
	// whenever the fast oscillator is turned off
	// the fast oscillator is held on in run and idle clock-on while either tap needs it, so a
	// move from slow to fast powers it before the switch completes
	// the slow oscillator stays on except in deep stop; the watchdog
	// and time base enables follow the slow tick by one cycle
	// every output below is a flip-flop; enables lag the mode by one
	// cycle, which the port checks allow for with a settle margin
	// register state
	logic [2:0] clock_source_select; // source field
	logic       high_low_select;     // 1: undivided fast
	logic       idle_enable;         // halt enters idle
	logic       keep_clock_in_idle;  // aux bit seven
	logic       fast_osc_ready;      // fast stable flag
	logic       slow_osc_ready;      // slow stable flag
	// switching state
	logic [2:0] cur_src;    // divider tap now in use
	logic [2:0] pend_src;   // tap requested
	logic [2:0] sw_count;   // old clock ticks waited
	logic       sw_wait_tgt; // waiting for target tick
	logic [15:0] stab_count; // fast settle counter
	logic [1:0] slow_count; // slow ready counter
	logic       slow_alive_s; // synchronised alive level
	logic [6:0] fast_ticks; // divided fast ticks
	scm_mode_t  next_mode;  // mode decode

	// apb decode
	wire        acc      = psel && penable;
	wire        wr       = acc && pwrite;
	wire        hit_mode = paddr == SCM_MODE_OFFSET;
	wire        hit_aux  = paddr == SCM_AUX_OFFSET;
	wire        hit_stat = paddr == SCM_STAT_OFFSET;
	wire        hit_any  = hit_mode || hit_aux || hit_stat;
	wire [7:0]  mode_rd  = {clock_source_select, 1'b0, slow_osc_ready,
		fast_osc_ready, idle_enable, high_low_select}; // bit four zero
	wire [7:0]  aux_rd   = {keep_clock_in_idle, 7'h00};
	wire [2:0]  req_src  = scm_src(high_low_select,
		clock_source_select);
	wire        running  = mode == SCM_FAST_RUN || mode == SCM_SLOW_RUN;
	// tick of any tap; tap zero is slow oscillator
	wire        src_tick_cur = cur_src == 3'h0 ? slow_osc_tick :
		fast_ticks[3'h7 - cur_src];
	wire        src_tick_tgt = pend_src == 3'h0 ? slow_osc_tick :
		fast_ticks[3'h7 - pend_src];
	// fast needed unless both taps are slow, or in sleep/idle-off
	wire        fast_need = (cur_src != 3'h0 || pend_src != 3'h0) &&
		(running || mode == SCM_IDLE_ON);
	wire        slow_need = mode != SCM_DEEP_STOP;

	// halt decode into the four stop states
	always_comb
	begin
		next_mode = mode;
		if (running && halt_req)
		begin
			if (!idle_enable)
				next_mode = watchdog_enable ? SCM_WDOG_STOP
					: SCM_DEEP_STOP;
			else
				next_mode = keep_clock_in_idle ? SCM_IDLE_ON
					: SCM_IDLE_OFF;
		end
		else if (!running && wake_req)
			next_mode = cur_src == 3'h0 ? SCM_SLOW_RUN : SCM_FAST_RUN;
		else if (running)
			next_mode = cur_src == 3'h0 ? SCM_SLOW_RUN : SCM_FAST_RUN;
	end

	scm_clk_div u_div (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.run      (fast_osc_on),
		.osc_tick (fast_osc_tick),
		.ticks    (fast_ticks)
	);

	scm_sync3 u_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       (slow_osc_alive),
		.q       (slow_alive_s)
	);

	// register writes; ready flags and bit four are not writable
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			clock_source_select <= SCM_CKS_RST;
			high_low_select     <= SCM_HL_RST;
			idle_enable         <= SCM_IDLE_RST;
			keep_clock_in_idle  <= SCM_KEEP_RST;
		end
		else if (wr && hit_mode)
		begin
			clock_source_select <= pwdata[SCM_CKS_LSB +: 3];
			high_low_select     <= pwdata[SCM_HL_BIT];
			idle_enable         <= pwdata[SCM_IDLE_BIT];
		end
		else if (wr && hit_aux)
			keep_clock_in_idle <= pwdata[SCM_KEEP_BIT];
	end

	// apb answer: zero wait, unmapped reads zero with slverr
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit_any;
			if (hit_mode)
				prdata <= {24'h000000, mode_rd};
			else if (hit_aux)
				prdata <= {24'h000000, aux_rd};
			else if (hit_stat)
				prdata <= {29'h0000_0000, mode};
			else
				prdata <= 32'h0000_0000;
		end
	end

	// source switch: wait four old ticks, then one target tick
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			cur_src     <= 3'h7;
			pend_src    <= 3'h7;
			sw_count    <= 3'h0;
			sw_wait_tgt <= 1'b0;
		end
		else if (req_src != pend_src)
		begin
			pend_src    <= req_src; // restart on any new request
			sw_count    <= 3'h0;
			sw_wait_tgt <= 1'b0;
		end
		else if (pend_src != cur_src)
		begin
			if (!sw_wait_tgt && src_tick_cur)
			begin
				if (sw_count == 3'(SCM_SYNC_CYC - 1))
					sw_wait_tgt <= 1'b1;
				sw_count <= sw_count + 3'h1;
			end
			else if (sw_wait_tgt && src_tick_tgt &&
				(pend_src == 3'h0 || fast_osc_ready))
			begin
				cur_src     <= pend_src; // edge aligned, no runt
				sw_wait_tgt <= 1'b0;
			end
		end
	end

	// oscillator ready flags
	always_ff @(posedge ref_clk)
	begin
		if (rst || !fast_osc_on)
		begin
			stab_count     <= 16'h0000;
			fast_osc_ready <= 1'b0;
		end
		else if (stab_count == 16'(SCM_FAST_STAB_CYC))
			fast_osc_ready <= 1'b1;
		else
			stab_count <= stab_count + 16'h0001;
		if (rst || mode == SCM_DEEP_STOP || !slow_alive_s)
		begin
			slow_count     <= 2'h0;
			slow_osc_ready <= 1'b0;
		end
		else if (slow_osc_tick && !slow_osc_ready)
		begin
			slow_count <= slow_count + 2'h1;
			if (slow_count == 2'(SCM_SLOW_RDY_CYC - 1))
				slow_osc_ready <= 1'b1;
		end
	end

	// mode and clock gating outputs, all registered
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			mode                  <= SCM_FAST_RUN;
			sys_clk_en            <= 1'b0;
			cpu_clk_en            <= 1'b0;
			fast_osc_on           <= 1'b1;
			slow_osc_on           <= 1'b1;
			time_base_clock       <= 1'b0;
			watchdog_clk_en       <= 1'b0;
			watchdog_clear        <= 1'b0;
			power_down_flag       <= 1'b0;
			watchdog_timeout_flag <= 1'b0;
		end
		else
		begin
			mode        <= next_mode;
			fast_osc_on <= fast_need;
			slow_osc_on <= slow_need;
			// cpu ticks only in run modes
			cpu_clk_en  <= running && src_tick_cur;
			// system clock also runs in idle clock-on
			sys_clk_en  <= (running || mode == SCM_IDLE_ON) &&
				src_tick_cur;
			time_base_clock <= slow_osc_tick && (running ||
				mode == SCM_IDLE_OFF || mode == SCM_IDLE_ON);
			watchdog_clk_en <= slow_osc_tick && watchdog_enable &&
				mode != SCM_DEEP_STOP;
			watchdog_clear <= running && halt_req;
			if (running && halt_req)
			begin
				power_down_flag       <= 1'b1;
				watchdog_timeout_flag <= 1'b0;
			end
		end
	end
endmodule : scm_mode_ctrl

/* rtl/scm_pkg.sv */
// scm_pkg: constants for the system clock and mode control block
// assumes one 100 MHz ref_clk domain; oscillators modelled as enables
package scm_pkg;
	// register map (apb byte addresses)
	localparam logic [11:0] SCM_MODE_OFFSET = 12'h000; // main mode reg
	localparam logic [11:0] SCM_AUX_OFFSET  = 12'h004; // aux mode reg
	localparam logic [11:0] SCM_STAT_OFFSET = 12'h008; // live status
	// main mode register fields
	localparam int SCM_HL_BIT   = 0; // high/low select
	localparam int SCM_IDLE_BIT = 1; // idle enable
	localparam int SCM_FRDY_BIT = 2; // fast ready, read only
	localparam int SCM_SRDY_BIT = 3; // slow ready, read only
	localparam int SCM_CKS_LSB  = 5; // source select field
	localparam int SCM_KEEP_BIT = 7; // keep clock in idle (aux reg)
	// reset values
	localparam logic [2:0] SCM_CKS_RST  = 3'h0;
	localparam logic       SCM_HL_RST   = 1'b1;
	localparam logic       SCM_IDLE_RST = 1'b1;
	localparam logic       SCM_KEEP_RST = 1'b0;
	// timing; fast settle in ref_clk cycles, slow ready and switch in ticks
	localparam int SCM_CLK_MHZ       = 100;
	localparam int SCM_FAST_STAB_NS  = 1000; // fast osc settle time
	localparam int SCM_FAST_STAB_CYC = (SCM_FAST_STAB_NS*SCM_CLK_MHZ+999)/1000;
	localparam int SCM_SLOW_RDY_CYC  = 2;    // slow ready after two ticks
	localparam int SCM_SYNC_CYC      = 4;    // switch delay in old clocks
	// operating modes
	typedef enum logic [2:0] {
		SCM_FAST_RUN   = 3'b000,
		SCM_SLOW_RUN   = 3'b001,
		SCM_IDLE_OFF   = 3'b010,
		SCM_IDLE_ON    = 3'b011,
		SCM_DEEP_STOP  = 3'b100,
		SCM_WDOG_STOP  = 3'b101
	} scm_mode_t;
	// divider select: 0 = slow osc, 1..6 = /64../2, 7 = /1
	function automatic logic [2:0] scm_src(input logic hl,
		input logic [2:0] cks);
		if (hl)
			return 3'h7;
		else if (cks[2:1] == 2'b00)
			return 3'h0;
		else
			return cks - 3'h1;
	endfunction : scm_src
endpackage : scm_pkg

/* rtl/scm_clk_div.sv */
// scm_clk_div: fast oscillator divider giving 1/1..1/64 tick enables
// assumes osc_tick is a one-cycle enable from the fast oscillator model
`timescale 1ns/1ps
module scm_clk_div
	import scm_pkg::*;
(
	input  wire logic       ref_clk,  // system clock
	input  wire logic       rst,      // sync reset
	input  wire logic       run,      // fast oscillator on
	input  wire logic       osc_tick, // one fast period
	output logic [6:0]      ticks     // bit k: tick every 2^k periods
);
	logic [5:0] count; // ripple-free binary divider
	// counter advances on each fast tick while oscillator runs
	always_ff @(posedge ref_clk)
	begin
		if (rst || !run)
			count <= 6'h00;
		else if (osc_tick)
			count <= count + 6'h01;
	end
	assign ticks[0] = run && osc_tick;
	genvar k;
	// a divided tick fires when the low k bits are all ones, just before they wrap
	generate
		for (k = 1; k < 7; k++)
		begin : g_div
			assign ticks[k] = run && osc_tick && (&count[k-1:0]);
		end
	endgenerate
endmodule : scm_clk_div

/* rtl/scm_sync3.sv */
// scm_sync3: three flop synchroniser with agreement filter
// assumes d comes from outside the ref_clk domain
`timescale 1ns/1ps
module scm_sync3
	import scm_pkg::*;
(
	input  wire logic ref_clk, // system clock
	input  wire logic rst,     // sync reset
	input  wire logic d,       // async input
	output logic      q        // filtered level
);
	logic s1; // metastable stage, read only by s2
	logic s2; // second stage
	logic s3; // third stage
	// shift chain; q changes only when stages two and three agree
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			q  <= 1'b0;
		end
		else
		begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q <= s3;
		end
	end
endmodule : scm_sync3

/* verif/scm_mode_ctrl_monitor.sv */
// scm_mode_ctrl_monitor: port-level checks bound onto scm_mode_ctrl
// assumes one ref_clk domain and a sync active-high rst
`timescale 1ns/1ps
module scm_mode_ctrl_monitor
	import scm_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        halt_req,
	input wire logic        slow_osc_tick,
	input wire logic        sys_clk_en,
	input wire logic        cpu_clk_en,
	input wire logic        slow_osc_on,
	input wire logic        time_base_clock,
	input wire logic        watchdog_clk_en,
	input wire logic        watchdog_clear,
	input wire logic        power_down_flag,
	input wire logic        watchdog_timeout_flag,
	input wire scm_mode_t   mode
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// halt is only honoured from a run mode
	wire run_m = (mode == SCM_FAST_RUN) || (mode == SCM_SLOW_RUN);
	// zero-wait slave: ready lands in the access cycle
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("apb ready missing");
	// nothing is mapped above the status word
	bad_addr_a: assert property (psel && !penable && paddr > 12'h008
		|=> pslverr) else $error("unmapped access not refused");
	halt_mode_a: assert property (halt_req && run_m |=> !run_m)
		else $error("halt left core running");
	halt_flags_a: assert property (halt_req && run_m |=>
		power_down_flag && !watchdog_timeout_flag) else $error("halt flags");
	wdog_clear_a: assert property (halt_req && run_m |=> watchdog_clear)
		else $error("watchdog not cleared on halt");
	// three cycles settle allows for registered enables lagging the mode
	deep_off_a: assert property ((mode == SCM_DEEP_STOP)[*3] |->
		!slow_osc_on && !sys_clk_en && !cpu_clk_en && !watchdog_clk_en
		&& !time_base_clock) else $error("clock alive in deep stop");
	wdog_keep_a: assert property ((mode == SCM_WDOG_STOP)[*3] |->
		slow_osc_on && !sys_clk_en && !cpu_clk_en)
		else $error("watchdog stop clocks wrong");
	idle_off_a: assert property ((mode == SCM_IDLE_OFF)[*3] |->
		slow_osc_on && !sys_clk_en && !cpu_clk_en)
		else $error("idle clock-off clocks wrong");
	idle_on_a: assert property ((mode == SCM_IDLE_ON)[*3] |->
		slow_osc_on && !cpu_clk_en) else $error("idle clock-on clocks wrong");
	tbase_run_a: assert property (mode == SCM_FAST_RUN && slow_osc_tick
		&& !halt_req |=> time_base_clock) else $error("time base stalled");
endmodule : scm_mode_ctrl_monitor

bind scm_mode_ctrl scm_mode_ctrl_monitor i_scm_mode_ctrl_monitor (
	.ref_clk               (ref_clk),
	.rst                   (rst),
	.psel                  (psel),
	.penable               (penable),
	.paddr                 (paddr),
	.pready                (pready),
	.pslverr               (pslverr),
	.halt_req              (halt_req),
	.slow_osc_tick         (slow_osc_tick),
	.sys_clk_en            (sys_clk_en),
	.cpu_clk_en            (cpu_clk_en),
	.slow_osc_on           (slow_osc_on),
	.time_base_clock       (time_base_clock),
	.watchdog_clk_en       (watchdog_clk_en),
	.watchdog_clear        (watchdog_clear),
	.power_down_flag       (power_down_flag),
	.watchdog_timeout_flag (watchdog_timeout_flag),
	.mode                  (mode)
);

/* verif/scm_core_model.sv */
// scm_core_model: oscillator side seen by the mode controller
// assumes ref_clk at 100 MHz; ticks are one-cycle enables
`timescale 1ns/1ps
module scm_core_model
	#(parameter int SLOW_DIV = 8) // slow period in ref_clk cycles
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic fast_osc_on,
	input wire logic slow_osc_on,
	output logic     fast_osc_tick,
	output logic     slow_osc_tick,
	output logic     slow_osc_alive
);
	logic [7:0] cnt = 8'h00; // slow period counter
	initial
	begin
		fast_osc_tick = 1'b0;
		slow_osc_tick = 1'b0;
		slow_osc_alive = 1'b0;
	end
	// a stopped oscillator gives no ticks, so a leak shows as a rate
	always @(posedge ref_clk)
	begin
		fast_osc_tick <= fast_osc_on && !rst;
		slow_osc_alive <= slow_osc_on;
		cnt <= (!slow_osc_on || cnt == SLOW_DIV - 1) ? 8'h00 : cnt + 8'h01;
		slow_osc_tick <= slow_osc_on && cnt == SLOW_DIV - 1;
	end
endmodule : scm_core_model

/* verif/tb_scm_mode_ctrl.sv */
// tb_scm_mode_ctrl: self-checking bench for the mode controller
// assumes scm_core_model supplies oscillators; bench is apb master
`timescale 1ns/1ps
module tb_scm_mode_ctrl import scm_pkg::*;;
	logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, halt_req = 1'b0, wake_req = 1'b0;
	logic        watchdog_enable = 1'b0, perr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, sys_clk_en, cpu_clk_en, fast_osc_on;
	logic        slow_osc_on, time_base_clock, watchdog_clk_en;
	logic        watchdog_clear, power_down_flag, watchdog_timeout_flag;
	logic        fast_osc_tick, slow_osc_tick, slow_osc_alive;
	scm_mode_t   mode;
	int          mismatches = 0, comparisons = 0;
	always #5 ref_clk = ~ref_clk;
	scm_mode_ctrl i_scm_mode_ctrl (
		.ref_clk               (ref_clk),
		.rst                   (rst),
		.psel                  (psel),
		.penable               (penable),
		.pwrite                (pwrite),
		.paddr                 (paddr),
		.pwdata                (pwdata),
		.prdata                (prdata),
		.pready                (pready),
		.pslverr               (pslverr),
		.fast_osc_tick         (fast_osc_tick),
		.slow_osc_tick         (slow_osc_tick),
		.slow_osc_alive        (slow_osc_alive),
		.halt_req              (halt_req),
		.wake_req              (wake_req),
		.watchdog_enable       (watchdog_enable),
		.sys_clk_en            (sys_clk_en),
		.cpu_clk_en            (cpu_clk_en),
		.fast_osc_on           (fast_osc_on),
		.slow_osc_on           (slow_osc_on),
		.time_base_clock       (time_base_clock),
		.watchdog_clk_en       (watchdog_clk_en),
		.watchdog_clear        (watchdog_clear),
		.power_down_flag       (power_down_flag),
		.watchdog_timeout_flag (watchdog_timeout_flag),
		.mode                  (mode)
	);
	scm_core_model i_scm_core_model (
		.ref_clk        (ref_clk),
		.rst            (rst),
		.fast_osc_on    (fast_osc_on),
		.slow_osc_on    (slow_osc_on),
		.fast_osc_tick  (fast_osc_tick),
		.slow_osc_tick  (slow_osc_tick),
		.slow_osc_alive (slow_osc_alive)
	);
	task test_done;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk
	// one apb transfer, held until ready is sampled high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			mismatches++;
			test_done();
		end
	endtask : apb
	// counts an enable over w cycles; within one of e is a match
	task rate(input string n, input logic s, input int w, input int e);
		int c;
		c = 0;
		repeat (w)
		begin
			@(posedge ref_clk);
			c += s ? int'(sys_clk_en) : int'(cpu_clk_en);
		end
		chk(n, e, (c >= e - 1 && c <= e + 1) ? e : c);
	endtask : rate
	task t_regs;
		apb(0, SCM_MODE_OFFSET, 0);
		chk("mode_reset", 32'h03, rd);
		apb(0, 12'h00C, 0);
		chk("unmapped_err", 1, perr);
		apb(1, SCM_AUX_OFFSET, 32'h80);
		apb(0, SCM_AUX_OFFSET, 0);
		chk("aux_keep", 32'h80, rd);
		apb(1, SCM_AUX_OFFSET, 0);
		repeat (150) @(posedge ref_clk);
		apb(1, SCM_MODE_OFFSET, 32'h13);
		apb(0, SCM_MODE_OFFSET, 0);
		chk("mode_ro_bits", 32'h0F, rd);
	endtask : t_regs
	// every source code, then back to the undivided fast clock
	task t_src;
		logic [2:0] c;
		for (int k = 2; k < 11; k++)
		begin
			c = k[2:0];
			apb(1, SCM_MODE_OFFSET, (k == 10) ? 32'h03 : {c, 5'h02});
			repeat (400) @(posedge ref_clk);
			if (k == 10)
				rate("cpu_fast1", 0, 256, 256);
			else if (k > 7)
			begin
				rate("cpu_slow", 0, 256, 32);
				chk("fast_off", 0, fast_osc_on);
			end
			else
				rate("cpu_div", 0, 256, 256 >> (8 - k));
			apb(0, SCM_STAT_OFFSET, 0);
			chk("stat_mode", (k == 8 || k == 9) ? SCM_SLOW_RUN :
				SCM_FAST_RUN, rd);
		end
	endtask : t_src
	// the four halt states, each left again by a wake event
	task t_halt;
		scm_mode_t x[4];
		x = '{SCM_DEEP_STOP, SCM_WDOG_STOP, SCM_IDLE_OFF, SCM_IDLE_ON};
		for (int k = 0; k < 4; k++)
		begin
			apb(1, SCM_AUX_OFFSET, {24'h0, k == 3, 7'h0});
			apb(1, SCM_MODE_OFFSET, {30'h0, k > 1, 1'b1});
			@(posedge ref_clk);
			watchdog_enable <= k == 1;
			halt_req <= 1'b1;
			@(posedge ref_clk);
			halt_req <= 1'b0;
			repeat (30) @(posedge ref_clk);
			chk("halt_mode", x[k], mode);
			chk("pd_flag", 1, power_down_flag);
			chk("to_flag", 0, watchdog_timeout_flag);
			chk("slow_on", k != 0, slow_osc_on);
			rate("sys_idle", 1, 32, (k == 3) ? 32 : 0);
			apb(0, SCM_MODE_OFFSET, 0);
			chk("slow_ready", k != 0, rd[3]);
			wake_req <= 1'b1;
			@(posedge ref_clk);
			wake_req <= 1'b0;
			repeat (5) @(posedge ref_clk);
			chk("wake_mode", SCM_FAST_RUN, mode);
			repeat (150) @(posedge ref_clk);
		end
	endtask : t_halt
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs();
		t_src();
		t_halt();
		test_done();
	end
	// hang guard
	initial
	begin
		repeat (90000) @(posedge ref_clk);
		mismatches++;
		test_done();
	end
endmodule : tb_scm_mode_ctrl
